// *** hw/asr_host.sv ***
// host end: link clock divider, frame sequencer and result fifo
module asr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : asr_fifo

module asr_host
  import asr_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  asr_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [4:0] req_bits,
  output logic out_valid,
  input wire logic out_ready,
  output asr_pkg::asr_word_t out_data
);
  // ****************************************
  // frame sequencer
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_LOW = 2'b10,
    ST_HIGH = 2'b11
  } asr_state_t;

  function automatic logic [4:0] asr_clamp(input logic [4:0] b);
    asr_clamp = (b == 5'h00 || b > 5'h10) ? 5'h10 : b;
  endfunction : asr_clamp

  asr_state_t state_reg;
  logic [7:0] div_reg;
  logic [4:0] edge_reg;
  logic [4:0] last_edge_reg;
  logic [9:0] period_reg;
  logic cs_n_reg;
  logic sclk_reg;
  logic ready_reg;
  logic push_reg;
  asr_word_t shift_reg;
  logic [2:0] dout_sync;
  logic dout_val_reg;
  logic fifo_in_ready;
  logic take;
  logic half_done;
  logic rate_ok;

  assign take = req_valid && ready_reg;
  assign half_done = (div_reg == HALF_LAST);
  assign rate_ok = (period_reg >= PERIOD_MIN);

  // data line is from the other end's clock: three stages, accept on agreement
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dout_sync <= 3'h0;
      dout_val_reg <= 1'b0;
    end else begin
      dout_sync <= {dout_sync[1:0], link.dout};
      if (dout_sync[1] == dout_sync[2]) begin
        dout_val_reg <= dout_sync[2];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      period_reg <= PERIOD_MIN;
    end else if (take) begin
      period_reg <= 10'h000;
    end else if (!rate_ok) begin
      period_reg <= period_reg + 10'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst || state_reg == ST_IDLE || half_done) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // sclk held high while deselected, so the select fall never meets a rising edge
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b1;
      edge_reg <= 5'h00;
      last_edge_reg <= FRAME_EDGES;
      push_reg <= 1'b0;
    end else begin
      push_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            cs_n_reg <= 1'b0;
            edge_reg <= 5'h00;
            last_edge_reg <= LEAD_EDGE + asr_clamp(req_bits);
            state_reg <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (half_done) begin
            sclk_reg <= 1'b0;
            edge_reg <= edge_reg + 5'h01;
            state_reg <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (half_done) begin
            sclk_reg <= 1'b1;
            state_reg <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (half_done) begin
            if (edge_reg == last_edge_reg) begin
              cs_n_reg <= 1'b1;
              push_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end else begin
              sclk_reg <= 1'b0;
              edge_reg <= edge_reg + 5'h01;
              state_reg <= ST_LOW;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // capture at each rising edge from MSB_EDGE on, msb lands in bit 15, unread bits stay zero
  always_ff @(posedge core_clk) begin
    if (!nrst || take) begin
      shift_reg <= 16'h0000;
    end else if (state_reg == ST_LOW && half_done && edge_reg >= MSB_EDGE) begin
      shift_reg[4'(FRAME_EDGES - edge_reg)] <= dout_val_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_reg == ST_IDLE) && rate_ok && fifo_in_ready && !take && !push_reg;
    end
  end

  // ****************************************
  // result buffer
  // ****************************************
  asr_fifo #(
    .WIDTH(RESULT_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(push_reg),
    .in_ready(fifo_in_ready),
    .in_data(shift_reg),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign req_ready = ready_reg;
endmodule : asr_host

// *** common/asr_pkg.sv ***
// shared constants and types for the serial readout link
package asr_pkg;
  localparam int RESULT_BITS = 16;
  localparam logic [4:0] CONV_PERIODS = 5'h11;
  localparam logic [4:0] FRAME_EDGES = CONV_PERIODS + 5'h01;
  localparam logic [4:0] FIRST_EDGE = 5'h01;
  localparam logic [4:0] LEAD_EDGE = 5'h02;
  localparam logic [4:0] MSB_EDGE = 5'h03;
  localparam logic [4:0] EDGE_SAT = 5'h1f;
  localparam logic [15:0] SIGN_FLIP = 16'h8000;
  localparam int CORE_CLK_HZ = 100000000;
  localparam int SCLK_HZ = 5000000;
  localparam int MAX_RATE_SPS = 250000;
  localparam int SCLK_HALF_CYC = CORE_CLK_HZ / (2 * SCLK_HZ);
  localparam int MIN_PERIOD_CYC = (CORE_CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);
  localparam logic [9:0] PERIOD_MIN = 10'(MIN_PERIOD_CYC);
  localparam int FIFO_DEPTH = 8;
  typedef logic [15:0] asr_word_t;
endpackage : asr_pkg

// *** common/asr_link_if.sv ***
// three-wire link between host and converter
interface asr_link_if;
  logic cs_n;
  logic sclk;
  logic dout_o;
  logic dout_oe;
  logic dout;
  // undriven line reads low; the host never samples it then
  assign dout = dout_oe ? dout_o : 1'b0;
  modport device (input cs_n, input sclk, output dout_o, output dout_oe);
  modport host (output cs_n, output sclk, input dout);
endinterface : asr_link_if

// *** hw/asr_device.sv ***
// converter end: frame sequencing and bit-serial result
module asr_device
  import asr_pkg::*;
(
  asr_link_if.device link,
  input wire asr_pkg::asr_word_t sample_in,
  output logic acquiring
);
  // ****************************************
  // frame logic on the link clock
  // ****************************************
  // the link clock stops between frames, so deselect clears the frame
  // state asynchronously instead of waiting for an edge that never comes
  logic [4:0] edge_reg;
  logic [4:0] edge_next;
  asr_word_t held_reg;
  asr_word_t approx_reg;
  logic dout_reg;
  logic oe_reg;
  logic acq_reg;
  logic [3:0] bit_idx;
  asr_word_t trial;
  logic decided;

  assign edge_next = (edge_reg == EDGE_SAT) ? edge_reg : edge_reg + 5'h01;
  assign bit_idx = 4'(FRAME_EDGES - edge_next);
  assign trial = approx_reg | (16'h0001 << bit_idx);
  assign decided = (held_reg >= trial);

  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      edge_reg <= 5'h00;
    end else begin
      edge_reg <= edge_next;
    end
  end

  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      acq_reg <= 1'b1;
    end else if (edge_next == FIRST_EDGE) begin
      acq_reg <= 1'b0;
    end else if (edge_next == FRAME_EDGES) begin
      acq_reg <= 1'b1;
    end
  end

  // successive approximation over offset-binary; sign flip gives two's complement
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      held_reg <= 16'h0000;
      approx_reg <= 16'h0000;
    end else if (edge_next == FIRST_EDGE) begin
      held_reg <= sample_in ^ SIGN_FLIP;
      approx_reg <= 16'h0000;
    end else if (edge_next >= MSB_EDGE && edge_next <= FRAME_EDGES && decided) begin
      approx_reg <= trial;
    end
  end

  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      oe_reg <= 1'b0;
      dout_reg <= 1'b0;
    end else if (edge_next == LEAD_EDGE) begin
      oe_reg <= 1'b1;
      dout_reg <= 1'b0;
    end else if (edge_next >= MSB_EDGE && edge_next <= FRAME_EDGES) begin
      dout_reg <= decided ^ (edge_next == MSB_EDGE);
    end
  end

  assign link.dout_o = dout_reg;
  assign link.dout_oe = oe_reg;
  assign acquiring = acq_reg;
endmodule : asr_device

// *** tb/asr_link_assertions.sv ***
// link framing and host pacing checker
module asr_link_assertions
  import asr_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // helpers
  // ****
  logic [4:0] edge_reg;
  logic [9:0] gap_reg;
  logic cs_reg;
  // async clear: the link clock stops between frames
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      edge_reg <= 5'h00;
    end else if (edge_reg != EDGE_SAT) begin
      edge_reg <= edge_reg + 5'h01;
    end
  end
  always_ff @(posedge core_clk) begin
    cs_reg <= cs_n;
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      gap_reg <= PERIOD_MIN;
    end else if (cs_reg && !cs_n) begin
      gap_reg <= 10'h001;
    end else if (gap_reg != 10'h3ff) begin
      gap_reg <= gap_reg + 10'h001;
    end
  end
  sequence lead_zero_s;
    dout_oe && !dout_o && !dout;
  endsequence
  sequence sclk_back_s;
    ##10 $rose(sclk);
  endsequence
  first_float_a: assert property (@(posedge sclk) disable iff (cs_n)
    edge_reg == FIRST_EDGE |-> !dout_oe) else $error("output driven on first edge");
  lead_zero_a: assert property (@(posedge sclk) disable iff (cs_n)
    edge_reg == LEAD_EDGE |-> lead_zero_s) else $error("no leading zero");
  bits_driven_a: assert property (@(posedge sclk) disable iff (cs_n)
    edge_reg >= MSB_EDGE && edge_reg <= FRAME_EDGES |-> dout_oe) else $error("bit not driven");
  deselect_float_a: assert property (@(posedge core_clk) disable iff (!nrst)
    cs_n |-> !dout_oe) else $error("output driven while deselected");
  idle_sclk_a: assert property (@(posedge core_clk) disable iff (!nrst)
    cs_n && $past(cs_n) |-> $stable(sclk)) else $error("clock runs while deselected");
  rate_gap_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(cs_n) |-> gap_reg >= PERIOD_MIN) else $error("frames too close");
  cs_fall_high_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(cs_n) |-> sclk) else $error("select fell with clock low");
  sclk_half_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(sclk) |-> sclk_back_s) else $error("link clock half period wrong");
endmodule : asr_link_assertions

// *** tb/test_adc_serial_readout_power_cycling.sv ***
// bench joining host and converter over the link
module test_adc_serial_readout_power_cycling
  import asr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk;
  logic nrst;
  logic req_valid;
  logic req_ready;
  logic [4:0] req_bits;
  logic out_valid;
  logic out_ready;
  asr_word_t out_data;
  asr_word_t sample_in;
  logic acquiring;
  int n_fail;
  int n_compared;
  asr_word_t codes [8] = '{16'h7fff, 16'h8000, 16'h0001, 16'ha5c3,
                           16'hc3a5, 16'hc3a5, 16'hc3a5, 16'hc3a5};
  logic [4:0] nbits [8] = '{5'h10, 5'h10, 5'h10, 5'h10, 5'h0a, 5'h01, 5'h00, 5'h11};
  asr_link_if link ();
  asr_device i_asr_device (.link(link), .sample_in(sample_in), .acquiring(acquiring));
  asr_host i_asr_host (.core_clk(core_clk), .nrst(nrst), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_bits(req_bits), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  asr_link_assertions i_asr_link_assertions (.core_clk(core_clk), .nrst(nrst),
    .cs_n(link.cs_n), .sclk(link.sclk), .dout_o(link.dout_o), .dout_oe(link.dout_oe),
    .dout(link.dout));
  // ****
  // tasks
  // ****
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic request(input logic [4:0] n);
    int i;
    @(posedge core_clk);
    req_bits <= n;
    req_valid <= 1'b1;
    i = 0;
    do begin
      @(negedge core_clk);
      i++;
    end while (req_ready !== 1'b1 && i < 2000);
    check("req_ready", {15'h0, req_ready}, 16'h0001);
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask : request
  task automatic pop(input logic [15:0] exp);
    int i;
    @(posedge core_clk);
    out_ready <= 1'b1;
    i = 0;
    do begin
      @(negedge core_clk);
      i++;
    end while (out_valid !== 1'b1 && i < 2000);
    check("out_valid", {15'h0, out_valid}, 16'h0001);
    check("out_data", out_data, exp);
    @(posedge core_clk);
    out_ready <= 1'b0;
  endtask : pop
  // short frames keep only the leading bits
  function automatic logic [15:0] keep(input logic [15:0] v, input logic [4:0] n);
    int k;
    k = (n == 5'h00 || n > 5'h10) ? 16 : int'(n);
    return v & ~(16'hffff >> k);
  endfunction : keep
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req_bits = 5'h00;
    out_ready = 1'b0;
    sample_in = 16'h0000;
    n_fail = 0;
    n_compared = 0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      sample_in <= codes[i];
      request(nbits[i]);
      repeat (40) @(negedge core_clk);
      check("acquiring", {15'h0, acquiring}, 16'h0000);
      pop(keep(codes[i], nbits[i]));
      check("acquiring", {15'h0, acquiring}, 16'h0001);
      check("dout_oe", {15'h0, link.dout_oe}, 16'h0000);
    end
    $display("test full and short frames done");
    sample_in <= 16'h5a3c;
    // far side stalls while the fifo fills
    for (int i = 0; i < 8; i++) begin
      request(5'h10);
      repeat (380) @(negedge core_clk);
      check("req_ready", {15'h0, req_ready}, 16'h0000);
    end
    repeat (100) @(negedge core_clk);
    check("req_ready", {15'h0, req_ready}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      pop(16'h5a3c);
    end
    $display("test fifo fill and drain done");
    complete_run();
  end
endmodule : test_adc_serial_readout_power_cycling
